// ### verilog/rht_sensor_link.sv
// Purpose: device end of a two-wire humidity and temperature sensor link
// Assumes: link_sck is the host clock, data is open drain with pull-up
// Notes: data line has two pull-down sources, see port groups
//
// What this block does
// - link logic static, any clock rate
// - change data after fall, sample on rise
// - bit traffic stable while clock high; ready pull-down released on core clock after first readout rise
// - start sequence: data low, clock pulse, data high
// - eight command bits, address 000, MSB first
// - acknowledge low from 8th to 9th fall
// - command bytes for temperature and humidity conversion
// - status read, status write, reserved codes unanswered
// - soft reset clears status, 11 ms wait
// - conversion 11, 55 or 210 ms
// - pull data low when result ready
// - result held until read out
// - two result bytes, checksum, host acknowledges
// - results MSB first, right justified
// - ends after checksum ack or missing ack
// - returns to sleep once readout starts, on core clock after first readout rise
// - nine clocks plus start resets only interface
// - eight-bit checksum over each transaction
// - default 14-bit temperature, 12-bit humidity
// - status bit 0 lowers resolution
`include "rht_cfg.svh"

module rht_sensor_link #(
    parameter int PWRUP_CYC = `RHT_PWRUP_MS * `RHT_CLK_KHZ,
    parameter int SRST_CYC = `RHT_SRST_MS * `RHT_CLK_KHZ,
    parameter int CONV8_CYC = `RHT_CONV8_MS * `RHT_CLK_KHZ,
    parameter int CONV12_CYC = `RHT_CONV12_MS * `RHT_CLK_KHZ,
    parameter int CONV14_CYC = `RHT_CONV14_MS * `RHT_CLK_KHZ
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link clock from the host
    input wire logic link_sck,
    // Open-drain data line, bit traffic pull-down
    input wire logic data_in,
    output logic data_out,
    output logic data_oe_n,
    // Open-drain data line, ready indication pull-down
    output logic ready_pull_n,
    // Converter samples
    input wire logic [13:0] temp_raw,
    input wire logic [13:0] hum_raw,
    // Status to the rest of the chip
    output logic heater_en,
    output logic conv_busy
);

    // ---------------------------------------------------------------
    // Shared functions
    // ---------------------------------------------------------------

    // Bitwise checksum, MSB first, no final reversal
    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] b);
        logic [7:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            if (c[7] ^ b[i]) begin
                c = {c[6:0], 1'b0} ^ `RHT_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Command byte decode; wrong address or reserved code gives none
    function automatic rht_pkg::rht_op_t decode(input logic [7:0] b);
        rht_pkg::rht_op_t op;
        op = rht_pkg::OP_NONE;
        if (b[7:5] == `RHT_ADDR_OK) begin
            case (b[4:0])
                `RHT_CODE_TEMP: op = rht_pkg::OP_TEMP;
                `RHT_CODE_HUM: op = rht_pkg::OP_HUM;
                `RHT_CODE_STAT_RD: op = rht_pkg::OP_STRD;
                `RHT_CODE_STAT_WR: op = rht_pkg::OP_STWR;
                `RHT_CODE_SRST: op = rht_pkg::OP_SRST;
                default: op = rht_pkg::OP_NONE;
            endcase
        end
        return op;
    endfunction

    // ---------------------------------------------------------------
    // Link domain: clocked only by the host, so no timers live here
    // ---------------------------------------------------------------

    rht_pkg::rht_lstate_t lst_r;
    logic [2:0] lrst_sync_r;
    logic link_rst_r;
    logic data_at_rise_r;
    logic fall_hi_r;
    logic start_tog_r;
    logic start_ack_r;
    logic [2:0] bit_r;
    logic [1:0] byte_r;
    logic [7:0] sh_r;
    logic [7:0] crc_r;
    logic [2:0] status_r;
    rht_pkg::rht_op_t op_r;
    logic cmd_tog_r;
    logic rd_tog_r;
    logic data_oe_n_r;
    logic [15:0] res_word_r;

    logic start_new;
    logic [7:0] rx_byte;
    rht_pkg::rht_op_t rx_op;
    logic [7:0] cur_byte;
    logic [1:0] last_byte;

    // Start is raised by the falling-edge half, taken by the rising half
    assign start_new = start_tog_r != start_ack_r;
    assign rx_byte = {sh_r[6:0], data_in};
    assign rx_op = decode(rx_byte);
    assign last_byte = (op_r == rht_pkg::OP_STRD) ? `RHT_STAT_LAST : `RHT_MEAS_LAST;

    // Byte on the wire in the current send slot
    always_comb begin
        cur_byte = crc_r;
        if (op_r == rht_pkg::OP_STRD) begin
            if (byte_r == 2'h0) begin
                cur_byte = {5'h00, status_r};
            end
        end else if (byte_r == 2'h0) begin
            cur_byte = res_word_r[15:8];
        end else if (byte_r == 2'h1) begin
            cur_byte = res_word_r[7:0];
        end
    end

    // Reset brought over to the host clock; needs a few host clocks
    always_ff @(posedge link_sck) begin
        lrst_sync_r <= {lrst_sync_r[1:0], reset};
        if (lrst_sync_r[1] == lrst_sync_r[2]) begin
            link_rst_r <= lrst_sync_r[2];
        end
    end

    // Data level seen at each rising edge
    always_ff @(posedge link_sck) begin
        data_at_rise_r <= data_in;
    end

    // Start detect: fall during one high phase, rise during the next
    always_ff @(negedge link_sck) begin
        if (link_rst_r) begin
            fall_hi_r <= 1'b0;
            start_tog_r <= 1'b0;
        end else begin
            fall_hi_r <= data_at_rise_r & ~data_in;
            if (fall_hi_r && !data_at_rise_r && data_in) begin
                start_tog_r <= ~start_tog_r;
            end
        end
    end

    // Protocol state, advanced on rising edges only
    always_ff @(posedge link_sck) begin
        if (link_rst_r) begin
            lst_r <= rht_pkg::L_IDLE;
            start_ack_r <= 1'b0;
        end else if (start_new) begin
            lst_r <= rht_pkg::L_CMD;
            start_ack_r <= start_tog_r;
        end else begin
            case (lst_r)
                rht_pkg::L_CMD: begin
                    if (bit_r == 3'h7) begin
                        lst_r <= (rx_op == rht_pkg::OP_NONE) ? rht_pkg::L_IDLE : rht_pkg::L_CMDACK;
                    end
                end
                rht_pkg::L_CMDACK: begin
                    case (op_r)
                        rht_pkg::OP_TEMP, rht_pkg::OP_HUM: lst_r <= rht_pkg::L_WAIT;
                        rht_pkg::OP_STRD: lst_r <= rht_pkg::L_TX;
                        rht_pkg::OP_STWR: lst_r <= rht_pkg::L_RX;
                        default: lst_r <= rht_pkg::L_IDLE;
                    endcase
                end
                // Host clocks again only after the ready pull-down
                rht_pkg::L_WAIT: lst_r <= rht_pkg::L_TX;
                rht_pkg::L_TX: begin
                    if (bit_r == 3'h0) begin
                        lst_r <= rht_pkg::L_TXACK;
                    end
                end
                rht_pkg::L_TXACK: begin
                    if (!data_in && byte_r != last_byte) begin
                        lst_r <= rht_pkg::L_TX;
                    end else begin
                        lst_r <= rht_pkg::L_IDLE;
                    end
                end
                rht_pkg::L_RX: begin
                    if (bit_r == 3'h7) begin
                        lst_r <= rht_pkg::L_RXACK;
                    end
                end
                rht_pkg::L_RXACK: lst_r <= rht_pkg::L_IDLE;
                default: lst_r <= rht_pkg::L_IDLE;
            endcase
        end
    end

    // Bit and byte counters; send counts down, receive counts up
    always_ff @(posedge link_sck) begin
        if (link_rst_r) begin
            bit_r <= 3'h0;
            byte_r <= 2'h0;
        end else if (start_new) begin
            bit_r <= 3'h1;
            byte_r <= 2'h0;
        end else begin
            case (lst_r)
                rht_pkg::L_CMD, rht_pkg::L_RX: bit_r <= bit_r + 3'h1;
                rht_pkg::L_CMDACK: bit_r <= (op_r == rht_pkg::OP_STRD) ? 3'h7 : 3'h0;
                // Top result bit was carried by the ready pull-down
                rht_pkg::L_WAIT: bit_r <= 3'h6;
                rht_pkg::L_TX: bit_r <= bit_r - 3'h1;
                rht_pkg::L_TXACK: begin
                    bit_r <= 3'h7;
                    byte_r <= byte_r + 2'h1;
                end
                default: bit_r <= 3'h0;
            endcase
        end
    end

    // Incoming shift register, MSB first
    always_ff @(posedge link_sck) begin
        if (link_rst_r) begin
            sh_r <= 8'h00;
        end else if (start_new) begin
            sh_r <= {7'h00, data_in};
        end else if (lst_r == rht_pkg::L_CMD || lst_r == rht_pkg::L_RX) begin
            sh_r <= rx_byte;
        end
    end

    // Decoded command, held for the core until the next command
    always_ff @(posedge link_sck) begin
        if (link_rst_r) begin
            op_r <= rht_pkg::OP_NONE;
            cmd_tog_r <= 1'b0;
        end else if (!start_new && lst_r == rht_pkg::L_CMD && bit_r == 3'h7) begin
            op_r <= rx_op;
            if (rx_op != rht_pkg::OP_NONE) begin
                cmd_tog_r <= ~cmd_tog_r;
            end
        end
    end

    // Checksum runs over the command and every data byte
    always_ff @(posedge link_sck) begin
        if (link_rst_r || start_new) begin
            crc_r <= `RHT_CRC_INIT;
        end else if (lst_r == rht_pkg::L_CMD && bit_r == 3'h7) begin
            crc_r <= crc8(`RHT_CRC_INIT, rx_byte);
        end else if (lst_r == rht_pkg::L_RX && bit_r == 3'h7) begin
            crc_r <= crc8(crc_r, rx_byte);
        end else if (lst_r == rht_pkg::L_TX && bit_r == 3'h0 && byte_r != last_byte) begin
            crc_r <= crc8(crc_r, cur_byte);
        end
    end

    // Status register; connection reset leaves it alone
    always_ff @(posedge link_sck) begin
        if (link_rst_r) begin
            status_r <= `RHT_STAT_DEFAULT;
        end else if (!start_new && lst_r == rht_pkg::L_CMDACK && op_r == rht_pkg::OP_SRST) begin
            status_r <= `RHT_STAT_DEFAULT;
        end else if (!start_new && lst_r == rht_pkg::L_RX && bit_r == 3'h7) begin
            status_r <= rx_byte[2:0];
        end
    end

    // Readout start event towards the core
    always_ff @(posedge link_sck) begin
        if (link_rst_r) begin
            rd_tog_r <= 1'b0;
        end else if (!start_new && lst_r == rht_pkg::L_WAIT) begin
            rd_tog_r <= ~rd_tog_r;
        end
    end

    // Pin driver: changes only on falling edges, so stable while high
    always_ff @(negedge link_sck) begin
        if (link_rst_r) begin
            data_oe_n_r <= 1'b1;
        end else begin
            case (lst_r)
                rht_pkg::L_CMDACK: data_oe_n_r <= 1'b0;
                rht_pkg::L_RXACK: data_oe_n_r <= 1'b0;
                rht_pkg::L_TX: data_oe_n_r <= cur_byte[bit_r];
                default: data_oe_n_r <= 1'b1;
            endcase
        end
    end

    assign data_oe_n = data_oe_n_r;

    // ---------------------------------------------------------------
    // Core domain: timing of power-up, soft reset and conversion
    // ---------------------------------------------------------------

    localparam int XW = $bits(rht_pkg::rht_x_t);

    rht_pkg::rht_cstate_t cst_r;
    logic [21:0] cnt_r;
    logic [XW-1:0] xs1_r;
    logic [XW-1:0] xs2_r;
    logic [XW-1:0] xs3_r;
    logic [XW-1:0] xf_r;
    rht_pkg::rht_x_t xin;
    rht_pkg::rht_x_t xq;
    logic cmd_seen_r;
    logic rd_seen_r;
    logic is_hum_r;
    logic [15:0] res_nxt;
    logic ready_pull_n_r;
    logic heater_en_r;
    logic conv_busy_r;
    logic data_out_r;
    logic cmd_ev;
    logic rd_ev;

    assign xin = '{cmd_tog: cmd_tog_r, rd_tog: rd_tog_r, res_low: status_r[`RHT_STAT_RES_BIT],
                   heater: status_r[`RHT_STAT_HEAT_BIT]};

    // Three-stage synchroniser for the toggles and status bits leaving the link domain
    always_ff @(posedge clk) begin
        xs1_r <= xin;
        xs2_r <= xs1_r;
        xs3_r <= xs2_r;
    end

    // Each bit counts only once stages two and three agree
    generate
        for (genvar g = 0; g < XW; g++) begin : g_filt
            always_ff @(posedge clk) begin
                if (reset) begin
                    xf_r[g] <= 1'b0;
                end else if (xs2_r[g] == xs3_r[g]) begin
                    xf_r[g] <= xs3_r[g];
                end
            end
        end
    endgenerate

    assign xq = xf_r;
    assign cmd_ev = xq.cmd_tog != cmd_seen_r;
    assign rd_ev = xq.rd_tog != rd_seen_r;

    // Toggle history for event detection
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_seen_r <= 1'b0;
            rd_seen_r <= 1'b0;
        end else begin
            cmd_seen_r <= xq.cmd_tog;
            rd_seen_r <= xq.rd_tog;
        end
    end

    // Right-justified sample at the selected resolution
    always_comb begin
        if (is_hum_r) begin
            res_nxt = xq.res_low ? {8'h00, hum_raw[13:6]} : {4'h0, hum_raw[13:2]};
        end else begin
            res_nxt = xq.res_low ? {4'h0, temp_raw[13:2]} : {2'h0, temp_raw};
        end
    end

    // Core sequencer; a command op is stable once its toggle is seen
    always_ff @(posedge clk) begin
        if (reset) begin
            cst_r <= rht_pkg::C_PWRUP;
            cnt_r <= 22'(PWRUP_CYC - 1);
            is_hum_r <= 1'b0;
        end else if (cmd_ev && op_r == rht_pkg::OP_SRST) begin
            cst_r <= rht_pkg::C_PWRUP;
            cnt_r <= 22'(SRST_CYC - 1);
        end else if (cmd_ev && cst_r != rht_pkg::C_PWRUP &&
                     (op_r == rht_pkg::OP_TEMP || op_r == rht_pkg::OP_HUM)) begin
            cst_r <= rht_pkg::C_CONV;
            is_hum_r <= op_r == rht_pkg::OP_HUM;
            if (op_r == rht_pkg::OP_HUM) begin
                cnt_r <= xq.res_low ? 22'(CONV8_CYC - 1) : 22'(CONV12_CYC - 1);
            end else begin
                cnt_r <= xq.res_low ? 22'(CONV12_CYC - 1) : 22'(CONV14_CYC - 1);
            end
        end else begin
            case (cst_r)
                rht_pkg::C_PWRUP, rht_pkg::C_CONV: begin
                    if (cnt_r == 22'h000000) begin
                        cst_r <= (cst_r == rht_pkg::C_CONV) ? rht_pkg::C_READY : rht_pkg::C_SLEEP;
                    end else begin
                        cnt_r <= cnt_r - 22'h000001;
                    end
                end
                rht_pkg::C_READY: begin
                    if (rd_ev) begin
                        cst_r <= rht_pkg::C_SLEEP;
                    end
                end
                rht_pkg::C_SLEEP: cst_r <= rht_pkg::C_SLEEP;
                default: cst_r <= rht_pkg::C_SLEEP;
            endcase
        end
    end

    // Result held untouched until another conversion ends
    always_ff @(posedge clk) begin
        if (reset) begin
            res_word_r <= 16'h0000;
        end else if (cst_r == rht_pkg::C_CONV && cnt_r == 22'h000000 && !cmd_ev) begin
            res_word_r <= res_nxt;
        end
    end

    // Ready pull-down also supplies the first result bit, always zero
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_pull_n_r <= 1'b1;
        end else if (cmd_ev) begin
            ready_pull_n_r <= 1'b1;
        end else if (cst_r == rht_pkg::C_CONV && cnt_r == 22'h000000) begin
            ready_pull_n_r <= 1'b0;
        end else if (rd_ev) begin
            ready_pull_n_r <= 1'b1;
        end
    end

    // Status outputs and the constant low level of the open drain
    always_ff @(posedge clk) begin
        if (reset) begin
            heater_en_r <= 1'b0;
            conv_busy_r <= 1'b0;
            data_out_r <= 1'b0;
        end else begin
            heater_en_r <= xq.heater;
            conv_busy_r <= cst_r == rht_pkg::C_CONV && |cnt_r;
            data_out_r <= 1'b0;
        end
    end

    assign ready_pull_n = ready_pull_n_r;
    assign heater_en = heater_en_r;
    assign conv_busy = conv_busy_r;
    assign data_out = data_out_r;

endmodule // rht_sensor_link

// ### verilog/rht_cfg.svh
// Purpose: constants of the humidity and temperature sensor serial link
// Assumes: system clock of 10 MHz
// Notes: times are in ms, cycle counts are derived in the top module
`ifndef RHT_CFG_SVH
`define RHT_CFG_SVH

// Clock rate and documented times
`define RHT_CLK_KHZ 10000
`define RHT_PWRUP_MS 11
`define RHT_SRST_MS 11
`define RHT_CONV8_MS 11
`define RHT_CONV12_MS 55
`define RHT_CONV14_MS 210

// Command byte fields
`define RHT_ADDR_OK 3'h0
`define RHT_CODE_TEMP 5'h03
`define RHT_CODE_HUM 5'h05
`define RHT_CODE_STAT_RD 5'h07
`define RHT_CODE_STAT_WR 5'h06
`define RHT_CODE_SRST 5'h1E

// Status register layout and default
`define RHT_STAT_DEFAULT 3'h0
`define RHT_STAT_RES_BIT 0
`define RHT_STAT_OTP_BIT 1
`define RHT_STAT_HEAT_BIT 2

// Readout framing: index of the last byte of each answer
`define RHT_MEAS_LAST 2'h2
`define RHT_STAT_LAST 2'h1

// Checksum generator and start value
`define RHT_CRC_POLY 8'h31
`define RHT_CRC_INIT 8'h00

`endif

// ### verilog/rht_pkg.sv
// Purpose: types shared by the sensor serial link
// Assumes: nothing beyond the constants header
// Notes: states are one-hot, commands are a plain code
package rht_pkg;

    // Link-side protocol states
    typedef enum logic [7:0] {
        L_IDLE   = 8'h01,
        L_CMD    = 8'h02,
        L_CMDACK = 8'h04,
        L_WAIT   = 8'h08,
        L_TX     = 8'h10,
        L_TXACK  = 8'h20,
        L_RX     = 8'h40,
        L_RXACK  = 8'h80
    } rht_lstate_t;

    // Core states on the internal oscillator
    typedef enum logic [3:0] {
        C_PWRUP = 4'h1,
        C_SLEEP = 4'h2,
        C_CONV  = 4'h4,
        C_READY = 4'h8
    } rht_cstate_t;

    // Decoded commands
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_TEMP = 3'h1,
        OP_HUM  = 3'h2,
        OP_STRD = 3'h3,
        OP_STWR = 3'h4,
        OP_SRST = 3'h5
    } rht_op_t;

    // Levels and toggles passed from link domain to core domain
    typedef struct packed {
        logic cmd_tog;
        logic rd_tog;
        logic res_low;
        logic heater;
    } rht_x_t;

endpackage

// ### tb/rht_link_sva.sv
// Purpose: protocol checker for the sensor serial link
// Assumes: link clock stands low between frames
// Notes: link checks count bits from each start sequence
`include "rht_cfg.svh"
module rht_link_sva #(
    parameter int SRST_CYC = 200,
    parameter int CONV8_CYC = 300,
    parameter int CONV12_CYC = 400,
    parameter int CONV14_CYC = 500
) (
    // Core side
    input wire logic clk,
    input wire logic reset,
    input wire logic ready_pull_n,
    input wire logic conv_busy,
    // Link side
    input wire logic link_sck,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic d_rise_r, oe_rise_r, start_r, cmd_ok;
    logic [21:0] busy_len_r;
    // Bit count restarts after each start, saturates after
    always_ff @(posedge link_sck) begin
        d_rise_r <= data_in;
        oe_rise_r <= data_oe_n;
        shift_r <= {shift_r[6:0], data_in};
        if (reset) begin
            bit_cnt_r <= 5'h1F;
        end else if (start_r) begin
            bit_cnt_r <= 5'h01;
        end else if (bit_cnt_r != 5'h1F) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end
    // Data rising while clock high marks the end of a start
    always_ff @(negedge link_sck) begin
        start_r <= data_in && !d_rise_r;
    end
    // Busy length, read in the cycle busy drops
    always_ff @(posedge clk) begin
        if (reset || !conv_busy) begin
            busy_len_r <= 22'h0;
        end else begin
            busy_len_r <= busy_len_r + 22'h1;
        end
    end
    assign cmd_ok = shift_r[7:5] == `RHT_ADDR_OK && shift_r[4:0] inside {`RHT_CODE_TEMP, `RHT_CODE_HUM,
        `RHT_CODE_STAT_RD, `RHT_CODE_STAT_WR, `RHT_CODE_SRST};
    sequence s_ack_free;
        !data_oe_n ##1 data_oe_n;
    endsequence
    property p_hold_high;
        @(negedge link_sck) disable iff (reset) data_oe_n == oe_rise_r;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("data moved while clock high");
    property p_cmd_ack;
        @(negedge link_sck) disable iff (reset) bit_cnt_r == 5'h08 && cmd_ok |=> !data_oe_n;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("command not acknowledged");
    property p_ack_free;
        @(negedge link_sck) disable iff (reset)
            bit_cnt_r == 5'h08 && cmd_ok && shift_r[4:0] != `RHT_CODE_STAT_RD |=> s_ack_free;
    endproperty
    a_ack_free: assert property (p_ack_free) else $error("ack not released at ninth fall");
    property p_no_ack;
        @(negedge link_sck) disable iff (reset) bit_cnt_r == 5'h08 && !cmd_ok |=> data_oe_n [*2];
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("bad command acknowledged");
    property p_low_only;
        @(posedge clk) disable iff (reset) !data_oe_n |-> data_out == 1'b0;
    endproperty
    a_low_only: assert property (p_low_only) else $error("data driven high");
    property p_busy_len;
        @(posedge clk) disable iff (reset) $fell(conv_busy) |-> busy_len_r inside {[CONV8_CYC - 1:CONV8_CYC + 1],
            [CONV12_CYC - 1:CONV12_CYC + 1], [CONV14_CYC - 1:CONV14_CYC + 1], [SRST_CYC - 1:SRST_CYC + 1]};
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");
    property p_ready;
        @(posedge clk) disable iff (reset)
            $fell(conv_busy) && !(busy_len_r inside {[SRST_CYC - 1:SRST_CYC + 1]}) |-> ##[0:3] !ready_pull_n;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after conversion");
    property p_rdy_idle;
        @(posedge clk) disable iff (reset) !ready_pull_n |-> !conv_busy;
    endproperty
    a_rdy_idle: assert property (p_rdy_idle) else $error("ready while busy");
endmodule // rht_link_sva

bind rht_sensor_link rht_link_sva #(.SRST_CYC(SRST_CYC), .CONV8_CYC(CONV8_CYC), .CONV12_CYC(CONV12_CYC),
    .CONV14_CYC(CONV14_CYC)) rht_link_sva_i (.clk(clk), .reset(reset), .ready_pull_n(ready_pull_n),
    .conv_busy(conv_busy), .link_sck(link_sck), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

// ### tb/rht_host_model.sv
// Purpose: host end of the two-wire link
// Assumes: bench resolves the wire level
// Notes: serial clock stands low between frames
module rht_host_model (
    // Link pins
    output logic sck,
    output logic pull,
    input wire logic wire_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: clock low, data released
    initial begin
        sck = 1'b0;
        pull = 1'b0;
    end
    // One clock: set data in the low phase, sample at the rise
    task automatic bit_clk(input logic b, input int lo, output logic r);
        pull = !b;
        #(lo);
        sck = 1'b1;
        r = wire_lvl;
        #20;
        sck = 1'b0;
        #4;
    endtask
    task automatic start_seq();
        pull = 1'b0;
        #24 sck = 1'b1;
        #12 pull = 1'b1;
        #12 sck = 1'b0;
        #24 sck = 1'b1;
        #12 pull = 1'b0;
        #12 sck = 1'b0;
        #4;
    endtask
    // Byte out MSB first, then the answer slot
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(b[i], 24, r);
        end
        bit_clk(1'b1, 24, ack);
    endtask
    // Second bit may be slowed so the ready pull clears first
    task automatic get_byte(input logic ack_low, input int slow_lo, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(1'b1, (i == 6) ? slow_lo : 24, b[i]);
        end
        bit_clk(!ack_low, 24, r);
        pull = 1'b0;
    endtask
    task automatic conn_reset();
        logic r;
        repeat (10) bit_clk(1'b1, 24, r);
    endtask
endmodule // rht_host_model

// ### tb/testbench.sv
// Purpose: self-checking bench for the sensor serial link
// Assumes: host model drives the link, bench the converter samples
// Notes: long counts shortened by parameters
`include "rht_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PWR = 200;
    localparam int SRST = 200;
    localparam int C8 = 300;
    localparam int C12 = 400;
    localparam int C14 = 500;
    logic clk, reset, sck, pull, data_w, data_out, data_oe_n, ready_pull_n, heater_en, conv_busy, cs_ack;
    logic [13:0] temp_raw, hum_raw;
    logic [2:0] st;
    logic [7:0] bad [4] = '{8'h23, 8'h01, 8'h15, 8'h1C};
    int mismatches, num_checks, cyc;
    rht_sensor_link #(.PWRUP_CYC(PWR), .SRST_CYC(SRST), .CONV8_CYC(C8), .CONV12_CYC(C12), .CONV14_CYC(C14))
        rht_sensor_link_i (.clk(clk), .reset(reset), .link_sck(sck), .data_in(data_w), .data_out(data_out),
        .data_oe_n(data_oe_n), .ready_pull_n(ready_pull_n), .temp_raw(temp_raw), .hum_raw(hum_raw),
        .heater_en(heater_en), .conv_busy(conv_busy));
    rht_host_model host_i (.sck(sck), .pull(pull), .wire_lvl(data_w));
    // Open-drain wire: any pull-down beats the pull-up
    assign data_w = !(pull || (!data_oe_n && !data_out) || !ready_pull_n);
    always #50 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            c = (c[7] ^ b[i]) ? ((c << 1) ^ `RHT_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
    task automatic cmd(input logic [7:0] c, input logic ack_exp);
        logic a;
        host_i.start_seq();
        host_i.put_byte(c, a);
        check(a, !ack_exp);
    endtask
    task automatic stat_read();
        logic [7:0] s, cs;
        cmd(8'h07, 1'b1);
        host_i.get_byte(1'b1, 24, s);
        host_i.get_byte(1'b1, 24, cs);
        check(s, {5'h00, st});
        check(cs, crc8(crc8(8'h00, 8'h07), {5'h00, st}));
    endtask
    // Temperature reads the checksum, humidity ends early
    task automatic measure(input logic is_t);
        logic [7:0] c, hi, lo, cs;
        logic [15:0] e;
        int n, e_cyc;
        c = is_t ? 8'h03 : 8'h05;
        e_cyc = is_t ? (st[0] ? C12 : C14) : (st[0] ? C8 : C12);
        @(negedge clk);
        temp_raw = 14'($urandom);
        hum_raw = 14'($urandom);
        cmd(c, 1'b1);
        n = 0;
        repeat (2) @(posedge clk);
        while (data_w !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check(16'(n >= e_cyc - 10 && n <= e_cyc + 10), 16'h1);
        repeat (20) @(posedge clk);
        check(data_w, 1'b0);
        host_i.get_byte(1'b1, 700, hi);
        host_i.get_byte(is_t, 24, lo);
        e = is_t ? (st[0] ? {4'h0, temp_raw[13:2]} : {2'h0, temp_raw})
            : (st[0] ? {8'h00, hum_raw[13:6]} : {4'h0, hum_raw[13:2]});
        check({hi, lo}, e);
        if (is_t) begin
            host_i.get_byte(1'b1, 24, cs);
            check(cs, crc8(crc8(crc8(8'h00, c), hi), lo));
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hDDBF6C11));
        clk = 1'b0;
        reset = 1'b1;
        temp_raw = 14'h0;
        hum_raw = 14'h0;
        st = 3'h0;
        fork
            host_i.conn_reset();
        join_none
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (PWR + 20) @(negedge clk);
        foreach (bad[i]) cmd(bad[i], 1'b0);
        stat_read();
        measure(1'b1);
        measure(1'b0);
        cmd(8'h06, 1'b1);
        host_i.put_byte(8'h05, cs_ack);
        check(cs_ack, 1'b0);
        st = 3'h5;
        repeat (10) @(negedge clk);
        check(heater_en, 1'b1);
        host_i.conn_reset();
        stat_read();
        measure(1'b1);
        measure(1'b0);
        cmd(8'h1E, 1'b1);
        st = 3'h0;
        repeat (SRST + 20) @(negedge clk);
        check(heater_en, 1'b0);
        stat_read();
        final_report();
    end
endmodule // testbench
